/* File: bench/thyristor_model.sv */
module thyristor_model (
  input  wire logic rst_i,
  input  wire logic gate_i,
  output logic      conducting_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // latches on the first gate edge; only reset drops it, like a dc-fed actuator
  always_ff @(posedge gate_i or posedge rst_i) begin
    if (rst_i) begin
      conducting_o <= 1'b0;
    end else begin
      conducting_o <= 1'b1;
    end
  end
endmodule

/* File: bench/trip_properties.sv */
module trip_checker #(
  parameter int unsigned CHANNELS       = 4,
  parameter int unsigned TICK_CYCLES    = 10,
  parameter int unsigned HIGH_TICKS     = 10,
  parameter int unsigned LOW_TICKS      = 6,
  parameter int unsigned DEGLITCH_TICKS = 1
) (
  input wire logic                             clk_i,
  input wire logic                             rst_i,
  input wire trip_pkg::window_t [CHANNELS-1:0] window_i,
  input wire trip_pkg::strap_t                 strap_i,
  input wire logic                             external_trip_input_i,
  input wire logic                             trip_pulse_o,
  input wire logic                             trip_declared_o,
  input wire logic                             gate_o
);
  // ----
  // run counters
  // ----
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  logic [31:0] age_q;
  // low and age counters saturate so a long idle never wraps into a false span
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_q <= '0;
      lo_q <= '1;
      age_q <= '1;
    end else begin
      hi_q <= trip_pulse_o ? hi_q + 32'h1 : '0;
      lo_q <= trip_pulse_o ? '0 : lo_q + {31'h0, ~&lo_q};
      age_q <= (window_i != '0) ? '0 : age_q + {31'h0, ~&age_q};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_gate_follows_ext: assert property (external_trip_input_i [*3] |=> gate_o)
    else $error("gate missed external trip");
  a_gate_idle_low: assert property ((!external_trip_input_i [*3] ##1 !trip_pulse_o) |-> !gate_o)
    else $error("gate high without cause");
  a_pulse_drives_gate: assert property (trip_pulse_o |-> gate_o)
    else $error("pulse not on gate");
  a_pulse_needs_trip: assert property ($rose(trip_pulse_o) |-> $past(trip_declared_o))
    else $error("pulse rose without trip");
  a_high_span_ok: assert property ($fell(trip_pulse_o) |->
    hi_q == HIGH_TICKS * TICK_CYCLES)
    else $error("pulse high span wrong");
  a_low_span_ok: assert property ($rose(trip_pulse_o) |-> lo_q >= LOW_TICKS * TICK_CYCLES)
    else $error("pulse low span short");
  a_rearm_on_trip: assert property ((!trip_pulse_o && trip_declared_o && lo_q > LOW_TICKS * TICK_CYCLES + 1)
    |=> trip_pulse_o)
    else $error("pulse not restarted");
  a_trip_has_cause: assert property ($rose(trip_declared_o) |-> age_q <= 8)
    else $error("trip without excursion");
  a_straps_disable: assert property ((strap_i == 2'b11) [*8] |-> !trip_declared_o)
    else $error("trip while straps off");
  a_reset_idle_low: assert property (disable iff (1'b0) rst_i |-> !trip_pulse_o && !gate_o && !trip_declared_o)
    else $error("outputs high in reset");

  c_pulse_start: cover property ($rose(trip_pulse_o));
  c_pulse_rearm: cover property ($rose(trip_pulse_o) && lo_q < 32'h10000);
  c_ext_only: cover property (gate_o && !trip_pulse_o);
endmodule

bind trip_sequencer trip_checker #(.CHANNELS(CHANNELS), .TICK_CYCLES(TICK_CYCLES), .HIGH_TICKS(HIGH_TICKS),
  .LOW_TICKS(LOW_TICKS), .DEGLITCH_TICKS(DEGLITCH_TICKS)) trip_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .window_i(window_i), .strap_i(strap_i), .external_trip_input_i(external_trip_input_i),
  .trip_pulse_o(trip_pulse_o), .trip_declared_o(trip_declared_o), .gate_o(gate_o));

/* File: bench/trip_sequencer_bench.sv */
module trip_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 10;
  logic                    clk_i;
  logic                    rst_i;
  logic                    ext;
  logic                    pulse;
  logic                    declared;
  logic                    gate;
  logic                    fired;
  trip_pkg::window_t [3:0] win;
  trip_pkg::strap_t        strap;
  int                      fail_count;
  int                      checks_done;
  int                      n;

  // short tick keeps a 16 ms period at 160 cycles
  trip_sequencer #(.TICK_CYCLES(TC), .DEGLITCH_TICKS(3)) trip_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .window_i(win), .strap_i(strap), .external_trip_input_i(ext), .trip_pulse_o(pulse),
    .trip_declared_o(declared), .gate_o(gate));
  thyristor_model thyristor_model_inst (.rst_i(rst_i), .gate_i(gate), .conducting_o(fired));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----
  // helpers
  // ----
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_span(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic drive(input logic [7:0] w, input logic e);
    @(posedge clk_i);
    win <= w;
    ext <= e;
    #1;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic run_of(input logic lvl, input int lim, output int r);
    r = 0;
    while (pulse === lvl && r < lim) begin
      idle(1);
      r++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic ext_test();
    drive(8'h00, 1'b1);
    idle(4);
    check_bit(gate, 1'b1);
    check_bit(pulse, 1'b0);
    drive(8'h00, 1'b0);
    idle(4);
    check_bit(gate, 1'b0);
  endtask
  task automatic glitch_test();
    drive(8'h08, 1'b0);
    idle(28);
    drive(8'h00, 1'b0);
    idle(40);
    check_bit(declared, 1'b0);
    check_bit(pulse, 1'b0);
  endtask
  task automatic rearm_test();
    drive(8'h80, 1'b0);
    run_of(1'b0, 60, n);
    check_bit(pulse, 1'b1);
    run_of(1'b1, 200, n);
    check_span(n, 10 * TC, 10 * TC);
    run_of(1'b0, 200, n);
    check_span(n, 6 * TC, 6 * TC);
    check_bit(pulse, 1'b1);
    drive(8'h00, 1'b0);
    run_of(1'b1, 200, n);
    run_of(1'b0, 300, n);
    check_span(n, 300, 300);
    check_bit(fired, 1'b1);
  endtask
  task automatic strap_test();
    @(posedge clk_i);
    strap <= 2'b01;
    drive(8'h10, 1'b0);
    idle(80);
    check_bit(declared, 1'b0);
    drive(8'h20, 1'b0);
    idle(60);
    check_bit(declared, 1'b1);
    drive(8'h00, 1'b0);
    run_of(1'b1, 200, n);
    run_of(1'b0, 300, n);
    @(posedge clk_i);
    strap <= 2'b11;
    drive(8'hff, 1'b0);
    idle(80);
    check_bit(declared, 1'b0);
    check_bit(pulse, 1'b0);
    drive(8'h00, 1'b0);
    @(posedge clk_i);
    strap <= 2'b00;
  endtask

  initial begin
    rst_i = 1'b1;
    win = '0;
    strap = '0;
    ext = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check_bit(pulse | gate | declared, 1'b0);
    idle(4);
    ext_test();
    glitch_test();
    rearm_test();
    strap_test();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule

/* File: include/trip_map.svh */
`ifndef TRIP_MAP_SVH
`define TRIP_MAP_SVH

// ----------------------------------------
// clock and time base
// ----------------------------------------
`define CLK_FREQ_HZ        50000000
`define TICK_TIME_US       1000
`define TICK_CYCLES        ((`CLK_FREQ_HZ / 1000000) * `TICK_TIME_US)

// ----------------------------------------
// pulse and deglitch times, in ticks of 1 ms
// ----------------------------------------
`define PULSE_HIGH_MS      10
`define PULSE_LOW_MS       6
`define DEGLITCH_MS        1

// ----------------------------------------
// channel count
// ----------------------------------------
`define CHANNEL_COUNT      4

`endif

/* File: include/trip_pkg.sv */
package trip_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_HIGH,
    SEQ_LOW
  } seq_state_t;

  // one channel's window comparator results
  typedef struct packed {
    logic above_high;
    logic below_low;
  } window_t;

  // threshold straps: set when the threshold pin is tied to the rail
  typedef struct packed {
    logic high_disabled;
    logic low_disabled;
  } strap_t;

endpackage

/* File: verilog/trip_deglitch.sv */
`include "trip_map.svh"

module trip_deglitch #(
  parameter int unsigned DEGLITCH_TICKS = `DEGLITCH_MS
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic raw_i,
  output logic      qualified_o
);

  localparam int unsigned CW = $clog2(DEGLITCH_TICKS + 2);

  if (DEGLITCH_TICKS < 1) begin : g_bad_params
    $error("deglitch must be at least one tick");
  end

  logic [CW-1:0] count_q;
  logic          qual_q;

  // ----------------------------------------
  // continuous-excursion timer
  // ----------------------------------------
  // a single low sample restarts the count, so short excursions never qualify;
  // the first tick may land at once, so one extra tick guarantees a whole N ms;
  // actual hold is between N and N+1 ms
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (!raw_i) begin
      count_q <= '0;
    end else if (tick_i && count_q < CW'(DEGLITCH_TICKS + 1)) begin
      count_q <= count_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      qual_q <= 1'b0;
    end else begin
      qual_q <= raw_i && (count_q >= CW'(DEGLITCH_TICKS + 1));
    end
  end

  assign qualified_o = qual_q;

endmodule

/* File: verilog/trip_sequencer.sv */
`include "trip_map.svh"

// Functional notes
// - trip when any of four channels stays out of window for the deglitch time
// - out of window means above high threshold or below low threshold
// - a declared trip yields one pulse: 10 ms high then 6 ms low
// - gate output is internal pulse ORed with the external trip input
// - trips during the 16 ms period neither restart nor extend it
// - trip still present at period end starts another identical pulse
// - trip cleared at period end returns output low until next trip
// - low threshold tied to rail makes under-threshold results ignored
module trip_sequencer #(
  parameter int unsigned CHANNELS       = `CHANNEL_COUNT,
  parameter int unsigned TICK_CYCLES    = `TICK_CYCLES,
  parameter int unsigned HIGH_TICKS     = `PULSE_HIGH_MS,
  parameter int unsigned LOW_TICKS      = `PULSE_LOW_MS,
  parameter int unsigned DEGLITCH_TICKS = `DEGLITCH_MS
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire trip_pkg::window_t [CHANNELS-1:0]  window_i,
  input  wire trip_pkg::strap_t                  strap_i,
  input  wire logic                              external_trip_input_i,
  output logic                                   trip_pulse_o,
  output logic                                   trip_declared_o,
  output logic                                   gate_o
);

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned PW = $clog2(HIGH_TICKS + LOW_TICKS + 1);

  // refuse sizes that the counters and the sequencer cannot serve;
  // a one-cycle tick would leave the time base no count to make
  if (CHANNELS < 1 || TICK_CYCLES < 2 || HIGH_TICKS < 1 ||
      LOW_TICKS < 1 || DEGLITCH_TICKS < 1) begin : g_bad_params
    $error("trip_sequencer parameters out of range");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // every pin level passes two flops; bits are independent levels,
  // so a bit that settles one cycle late only delays its own channel
  trip_pkg::window_t [CHANNELS-1:0] win_meta_q;
  trip_pkg::window_t [CHANNELS-1:0] win_sync_q;
  trip_pkg::strap_t                 strap_meta_q;
  trip_pkg::strap_t                 strap_sync_q;
  logic                             ext_meta_q;
  logic                             ext_sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_meta_q   <= '0;
      win_sync_q   <= '0;
      // straps default to disabled so nothing trips before they are sampled
      strap_meta_q <= '1;
      strap_sync_q <= '1;
      ext_meta_q   <= 1'b0;
      ext_sync_q   <= 1'b0;
    end else begin
      win_meta_q   <= window_i;
      win_sync_q   <= win_meta_q;
      strap_meta_q <= strap_i;
      strap_sync_q <= strap_meta_q;
      ext_meta_q   <= external_trip_input_i;
      ext_sync_q   <= ext_meta_q;
    end
  end

  // ----------------------------------------
  // 1 ms time base
  // ----------------------------------------
  logic [TW-1:0] tick_cnt_q;
  logic          tick;
  logic          restart_tick;

  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  // restarting the base at a new trip makes the first high ms a whole one;
  // it only ever delays the deglitch ticks, so no excursion qualifies early
  // and every later period boundary still falls on a tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
    end else if (tick || restart_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // ----------------------------------------
  // per-channel window check and deglitch
  // ----------------------------------------
  logic [CHANNELS-1:0] qualified;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic raw;

    // a threshold tied to the rail contributes nothing; the straps are
    // static board ties, so their sync delay only matters just after reset
    assign raw = (win_sync_q[ch].above_high && !strap_sync_q.high_disabled) ||
                 (win_sync_q[ch].below_low  && !strap_sync_q.low_disabled);

    trip_deglitch #(
      .DEGLITCH_TICKS (DEGLITCH_TICKS)
    ) u_deglitch (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .tick_i      (tick),
      .raw_i       (raw),
      .qualified_o (qualified[ch])
    );
  end

  logic trip_any;
  assign trip_any = |qualified;

  // ----------------------------------------
  // pulse sequencer
  // ----------------------------------------
  trip_pkg::seq_state_t state_q;
  logic [PW-1:0]        ms_q;
  logic                 pulse_q;
  logic                 pulse_d;
  logic                 gate_q;

  // only a trip seen while idle starts a period; later ones wait for its end
  assign restart_tick = (state_q == trip_pkg::SEQ_IDLE) && trip_any;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= trip_pkg::SEQ_IDLE;
      ms_q    <= '0;
    end else begin
      case (state_q)
        trip_pkg::SEQ_IDLE: begin
          ms_q <= '0;
          if (trip_any) begin
            state_q <= trip_pkg::SEQ_HIGH;
          end
        end
        trip_pkg::SEQ_HIGH: begin
          // trip_any not looked at here: pulse cannot be restarted
          if (tick) begin
            if (ms_q == PW'(HIGH_TICKS - 1)) begin
              ms_q    <= '0;
              state_q <= trip_pkg::SEQ_LOW;
            end else begin
              ms_q <= ms_q + PW'(1);
            end
          end
        end
        trip_pkg::SEQ_LOW: begin
          if (tick) begin
            if (ms_q == PW'(LOW_TICKS - 1)) begin
              ms_q <= '0;
              if (trip_any) begin
                state_q <= trip_pkg::SEQ_HIGH;
              end else begin
                state_q <= trip_pkg::SEQ_IDLE;
              end
            end else begin
              ms_q <= ms_q + PW'(1);
            end
          end
        end
        default: begin
          state_q <= trip_pkg::SEQ_IDLE;
          ms_q    <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // next pulse level, computed once so gate is always high while pulse is;
  // taken from the next state so both registers align with state_q,
  // which keeps the high half at exactly HIGH_TICKS ticks
  always_comb begin
    pulse_d = 1'b0;
    case (state_q)
      trip_pkg::SEQ_IDLE: begin
        pulse_d = trip_any;
      end
      trip_pkg::SEQ_HIGH: begin
        pulse_d = !(tick && ms_q == PW'(HIGH_TICKS - 1));
      end
      trip_pkg::SEQ_LOW: begin
        pulse_d = tick && ms_q == PW'(LOW_TICKS - 1) && trip_any;
      end
      default: begin
        pulse_d = 1'b0;
      end
    endcase
  end

  // pulse_q carries the sequencer alone; gate_q adds the external level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  // external level joins after its own sync, so it reaches the gate 3 edges late
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= pulse_d || ext_sync_q;
    end
  end

  assign trip_pulse_o    = pulse_q;
  assign trip_declared_o = trip_any;
  assign gate_o          = gate_q;

endmodule
